// [rtl/bdcd_pkg.sv]
// Notes on behaviour
// - Gate pump off in sleep or overheat
// - Four edge rates per half-bridge
// - Strap edge rate latched at power-up only
// - Serial edge rate writable; avoid while running
// - Low side waits for high-side gate off
// - Up to 300 ns extra delay allowed
// - Logic inputs default low when undriven
// - Controller drives PWM, disable and write inputs low during sleep
// - Chip select defaults high when undriven
// - Host pulls up fault and open-drain output
// - Push-pull output rail chosen by select bit
// - Strap pins decoded as four levels
// - Four sense gains from strap or bits
// - Gain strap resampled every 1 ms
// - New gain applied on low-side falling edge
// - Demag turns on diode-conducting transistor
// - Demag needs both rectification enables set; the strap variant takes mode pin bit 0 instead
// - Reverse comparators per half-bridge drive demag
// - Overcurrent disables active demagnetization
// - Commutation decay uses freewheeling transistor
// - High-side-only PWM: low side rectifies
// - Complementary PWM: low side off near zero
// - Scheme and enables read only at power-up
package bdcd_pkg;
   // ==========================================================
   // Codes and timing
   localparam logic [1:0] BDCD_SLEW_1V1 = 2'h0;
   localparam logic [1:0] BDCD_SLEW_0V5 = 2'h1;
   localparam logic [1:0] BDCD_SLEW_0V25 = 2'h2;
   localparam logic [1:0] BDCD_SLEW_0V05 = 2'h3;
   localparam logic [1:0] BDCD_GAIN_RESET = 2'h0;
   localparam logic [1:0] BDCD_SLEW_RESET = 2'h0;
   localparam logic [1:0] BDCD_MODE_RESET = 2'h0;
   localparam int BDCD_CLK_MHZ = 250;
   localparam int BDCD_GAIN_PERIOD_US = 1000;
   localparam int BDCD_GAIN_PERIOD_CYC = BDCD_GAIN_PERIOD_US * BDCD_CLK_MHZ;
   localparam int BDCD_DEMAG_DELAY_NS = 300;
   localparam int BDCD_DEMAG_DELAY_CYC = (BDCD_DEMAG_DELAY_NS * BDCD_CLK_MHZ) / 1000;
   localparam int BDCD_PHASES = 3;
   // Mode bit positions of the two-bit scheme code
   localparam int BDCD_MODE_DEMAG_BIT = 0;
   localparam int BDCD_MODE_3X_BIT = 1;
endpackage

// [rtl/bdcd_if.sv]
`timescale 1ns/1ps
// ==========================================================
// Link between motor controller and bridge driver logic
interface bdcd_if;
   logic [2:0] high_side_pwm_input;
   logic [2:0] low_side_pwm_input;
   logic driver_disable_input;
   logic sleep_request_low;
   logic serial_variant;
   logic [1:0] slew_strap;
   logic [1:0] gain_strap;
   logic [1:0] drive_config_pin;
   logic cfg_write;
   logic [1:0] cfg_slew;
   logic [1:0] cfg_gain;
   logic sync_rect_enable;
   logic async_rect_enable;
   logic pwm_3x_select;
   logic serial_out_rail_select;
   logic fault_flag_low_o;
   logic fault_flag_low_oe;
   modport device (
      input high_side_pwm_input, low_side_pwm_input, driver_disable_input,
      input sleep_request_low, serial_variant, slew_strap, gain_strap,
      input drive_config_pin, cfg_write, cfg_slew, cfg_gain, sync_rect_enable,
      input async_rect_enable, pwm_3x_select, serial_out_rail_select,
      output fault_flag_low_o, fault_flag_low_oe
   );
   modport host (
      output high_side_pwm_input, low_side_pwm_input, driver_disable_input,
      output sleep_request_low, serial_variant, slew_strap, gain_strap,
      output drive_config_pin, cfg_write, cfg_slew, cfg_gain, sync_rect_enable,
      output async_rect_enable, pwm_3x_select, serial_out_rail_select,
      input fault_flag_low_o, fault_flag_low_oe
   );
endinterface

// [rtl/bdcd_host.sv]
`timescale 1ns/1ps
// ==========================================================
// Controller end: registers user commands onto the link
module bdcd_host (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // User side
   input wire logic [2:0] user_high_pwm,
   input wire logic [2:0] user_low_pwm,
   input wire logic user_disable,
   input wire logic user_sleep_low,
   input wire logic user_serial_variant,
   input wire logic [1:0] user_slew_strap,
   input wire logic [1:0] user_gain_strap,
   input wire logic [1:0] user_mode_strap,
   input wire logic user_cfg_write,
   input wire logic [1:0] user_cfg_slew,
   input wire logic [1:0] user_cfg_gain,
   input wire logic user_sync_en,
   input wire logic user_async_en,
   input wire logic user_3x,
   input wire logic user_rail_sel,
   output logic user_fault,
   // Link
   bdcd_if.host link
);
   logic sleeping;
   // while sleep is requested the PWM, driver-disable and config-write inputs are forced low
   assign sleeping = ~user_sleep_low;

   // ==========================================================
   // Registered drive of every link signal
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         link.high_side_pwm_input <= 3'h0;
         link.low_side_pwm_input <= 3'h0;
         link.driver_disable_input <= 1'h0;
         link.sleep_request_low <= 1'h0;
         link.serial_variant <= 1'h0;
         link.slew_strap <= bdcd_pkg::BDCD_SLEW_RESET;
         link.gain_strap <= bdcd_pkg::BDCD_GAIN_RESET;
         link.drive_config_pin <= bdcd_pkg::BDCD_MODE_RESET;
         link.cfg_write <= 1'h0;
         link.cfg_slew <= bdcd_pkg::BDCD_SLEW_RESET;
         link.cfg_gain <= bdcd_pkg::BDCD_GAIN_RESET;
         link.sync_rect_enable <= 1'h0;
         link.async_rect_enable <= 1'h0;
         link.pwm_3x_select <= 1'h0;
         link.serial_out_rail_select <= 1'h0;
         user_fault <= 1'h0;
      end else begin
         link.high_side_pwm_input <= sleeping ? 3'h0 : user_high_pwm;
         link.low_side_pwm_input <= sleeping ? 3'h0 : user_low_pwm;
         link.driver_disable_input <= user_disable & ~sleeping;
         link.sleep_request_low <= user_sleep_low;
         link.serial_variant <= user_serial_variant;
         link.slew_strap <= user_slew_strap;
         link.gain_strap <= user_gain_strap;
         link.drive_config_pin <= user_mode_strap;
         link.cfg_write <= user_cfg_write & ~sleeping;
         link.cfg_slew <= user_cfg_slew;
         link.cfg_gain <= user_cfg_gain;
         link.sync_rect_enable <= user_sync_en;
         link.async_rect_enable <= user_async_en;
         link.pwm_3x_select <= user_3x;
         link.serial_out_rail_select <= user_rail_sel;
         // host-side pull-up resolves undriven fault line to high
         user_fault <= link.fault_flag_low_oe & ~link.fault_flag_low_o;
      end
   end
endmodule

// [rtl/bdcd_device.sv]
`timescale 1ns/1ps
// ==========================================================
// Device end: configuration capture, gate control, demag logic
module bdcd_device (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Link
   bdcd_if.device link,
   // Analog-side status
   input wire logic over_temp,
   input wire logic overcurrent_trip,
   input wire logic [2:0] high_side_reverse_comparator,
   input wire logic [2:0] low_side_reverse_comparator,
   input wire logic [2:0] high_gate_off,
   input wire logic [2:0] low_gate_off,
   input wire logic [2:0] commutation_decay,
   input wire logic [2:0] current_near_zero,
   input wire logic fault_event,
   // Driver outputs
   output logic gate_pump_enable,
   output logic [1:0] slew_code,
   output logic [1:0] sense_amp_gain_setting,
   output logic [2:0] high_gate_on,
   output logic [2:0] low_gate_on,
   output logic [2:0] phase_hiz,
   output logic demag_active,
   output logic pwm_3x_mode,
   output logic serial_out_rail,
   output logic [2:0] extra_delay_active
);
   typedef enum logic [1:0] {BDCD_SETTLE, BDCD_POWERUP, BDCD_RUN} bdcd_state_e;
   bdcd_state_e state;
   logic [17:0] gain_timer;
   logic [1:0] pending_gain;
   logic gain_pending;
   logic [2:0] low_prev;
   logic demag_en;
   logic demag_blocked;
   logic [2:0] hs_cmd;
   logic [2:0] ls_cmd;
   logic [2:0] hiz_cmd;
   logic [2:0] next_high;
   logic [2:0] next_low;
   logic [2:0] low_fall;
   logic gain_tick;
   logic [1:0] gain_src;
   logic gain_new;
   logic demag_cfg;
   logic [2:0] high_prev;
   logic [2:0] pin_edge;
   logic [2:0] delay_open;
   logic [2:0] rect_high;
   logic [2:0] rect_low;
   logic [2:0] aar_cut;

   // pull-downs and chip-select pull-up are pad cells outside this logic
   // Four-level strap pin to its two-bit code
   function automatic logic [1:0] bdcd_decode(input logic [1:0] lvl);
      bdcd_decode = lvl;
   endfunction

   // Phase command of one PWM pair: high side in bit 1, low side in bit 0
   function automatic logic [1:0] bdcd_phase_cmd(input logic scheme_3x, input logic hi,
                                                 input logic lo);
      if (scheme_3x) begin
         bdcd_phase_cmd = {lo & hi, lo & ~hi};
      end else begin
         bdcd_phase_cmd = {hi & ~lo, lo & ~hi};
      end
   endfunction

   // ==========================================================
   // Gain source, edge detect, timer tick
   assign gain_tick = (gain_timer == 18'(bdcd_pkg::BDCD_GAIN_PERIOD_CYC - 1));
   assign low_fall = low_prev & ~link.low_side_pwm_input;
   assign gain_src = link.serial_variant ? link.cfg_gain : bdcd_decode(link.gain_strap);
   assign gain_new = link.serial_variant ? link.cfg_write : gain_tick;
   assign demag_en = demag_cfg & ~demag_blocked;

   // Power-up capture, then run
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= BDCD_SETTLE;
         slew_code <= bdcd_pkg::BDCD_SLEW_RESET;
         pwm_3x_mode <= 1'h0;
         demag_cfg <= 1'h0;
      end else begin
         case (state)
            // Host flops load the user straps on the first edge out of reset
            BDCD_SETTLE: begin
               state <= BDCD_POWERUP;
            end
            BDCD_POWERUP: begin
               state <= BDCD_RUN;
               slew_code <= link.serial_variant ? link.cfg_slew
                                                : bdcd_decode(link.slew_strap);
               if (link.serial_variant) begin
                  pwm_3x_mode <= link.pwm_3x_select;
                  demag_cfg <= link.sync_rect_enable & link.async_rect_enable;
               end else begin
                  pwm_3x_mode <= link.drive_config_pin[bdcd_pkg::BDCD_MODE_3X_BIT];
                  demag_cfg <= link.drive_config_pin[bdcd_pkg::BDCD_MODE_DEMAG_BIT];
               end
            end
            BDCD_RUN: begin
               if (link.serial_variant && link.cfg_write) begin
                  slew_code <= link.cfg_slew;
               end
            end
            default: state <= BDCD_SETTLE;
         endcase
      end
   end

   // Gain resample timer and deferred application
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         gain_timer <= 18'h0;
         gain_pending <= 1'h0;
         pending_gain <= bdcd_pkg::BDCD_GAIN_RESET;
         sense_amp_gain_setting <= bdcd_pkg::BDCD_GAIN_RESET;
         low_prev <= 3'h0;
         high_prev <= 3'h0;
      end else begin
         gain_timer <= gain_tick ? 18'h0 : gain_timer + 18'h1;
         low_prev <= link.low_side_pwm_input;
         high_prev <= link.high_side_pwm_input;
         if (gain_new && state == BDCD_RUN) begin
            pending_gain <= gain_src;
            gain_pending <= 1'h1;
         end else if (|low_fall) begin
            gain_pending <= 1'h0;
         end
         if (gain_pending && |low_fall) begin
            sense_amp_gain_setting <= pending_gain;
         end
      end
   end

   // ==========================================================
   // PWM decode per half-bridge
   genvar g;
   generate
      for (g = 0; g < bdcd_pkg::BDCD_PHASES; g++) begin : g_phase
         assign {hs_cmd[g], ls_cmd[g]} = bdcd_phase_cmd(pwm_3x_mode,
                                         link.high_side_pwm_input[g],
                                         link.low_side_pwm_input[g]);
         assign hiz_cmd[g] = ~hs_cmd[g] & ~ls_cmd[g];
         // High side freewheels the commutation decay
         assign rect_high[g] = demag_en & hiz_cmd[g] & high_side_reverse_comparator[g]
                             & commutation_decay[g];
         // Low side conducts while its body diode would
         assign rect_low[g] = demag_en & hiz_cmd[g] & low_side_reverse_comparator[g];
         // Complementary low side cut as decay current nears zero
         assign aar_cut[g] = demag_en & current_near_zero[g];
         // Dead-time guard: low side only after the high gate is off
         assign next_high[g] = ~link.driver_disable_input & (hs_cmd[g] | rect_high[g]);
         assign next_low[g] = ~link.driver_disable_input & high_gate_off[g] & ~next_high[g]
                            & ((ls_cmd[g] & ~aar_cut[g]) | rect_low[g]);
      end
   endgenerate

   // ==========================================================
   // Extra-delay window per phase, opened by an input edge in demag
   generate
      for (g = 0; g < bdcd_pkg::BDCD_PHASES; g++) begin : g_delay
         logic [6:0] delay_count;
         assign pin_edge[g] = (low_prev[g] ^ link.low_side_pwm_input[g])
                            | (high_prev[g] ^ link.high_side_pwm_input[g]);
         assign delay_open[g] = (delay_count != 7'h0);
         // Reload on an edge, then count the window down
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               delay_count <= 7'h0;
            end else if (demag_en && pin_edge[g]) begin
               delay_count <= 7'(bdcd_pkg::BDCD_DEMAG_DELAY_CYC);
            end else if (delay_open[g]) begin
               delay_count <= delay_count - 7'h1;
            end
         end
      end
   endgenerate

   // Gate drive, pump enable, fault pin
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         high_gate_on <= 3'h0;
         low_gate_on <= 3'h0;
         phase_hiz <= 3'h7;
         gate_pump_enable <= 1'h0;
         demag_blocked <= 1'h0;
         serial_out_rail <= 1'h0;
         extra_delay_active <= 3'h0;
         demag_active <= 1'h0;
         link.fault_flag_low_o <= 1'h0;
         link.fault_flag_low_oe <= 1'h0;
      end else begin
         high_gate_on <= next_high & low_gate_off;
         low_gate_on <= next_low;
         phase_hiz <= ~(next_high | next_low);
         gate_pump_enable <= link.sleep_request_low & ~over_temp;
         if (overcurrent_trip) begin
            demag_blocked <= 1'h1;
         end else if (!link.sleep_request_low) begin
            demag_blocked <= 1'h0;
         end
         serial_out_rail <= link.serial_out_rail_select;
         extra_delay_active <= delay_open;
         // Overcurrent drops demag at once; the block holds until sleep
         demag_active <= demag_cfg & ~overcurrent_trip & ~demag_blocked;
         // Open drain: the pin is only ever pulled low
         link.fault_flag_low_o <= 1'h0;
         link.fault_flag_low_oe <= fault_event | overcurrent_trip | over_temp;
      end
   end
endmodule

// [verif/bdcd_monitor.sv]
`timescale 1ns/1ps
// ==========================================================
// Checks on the link and the driver outputs
module bdcd_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Link signals
   input wire logic sleep_request_low,
   input wire logic serial_variant,
   input wire logic [2:0] low_side_pwm_input,
   input wire logic fault_flag_low_o,
   // Device side
   input wire logic over_temp,
   input wire logic overcurrent_trip,
   input wire logic [2:0] high_gate_off,
   input wire logic [2:0] low_gate_off,
   input wire logic gate_pump_enable,
   input wire logic [1:0] slew_code,
   input wire logic [1:0] sense_amp_gain_setting,
   input wire logic [2:0] high_gate_on,
   input wire logic [2:0] low_gate_on,
   input wire logic demag_active,
   input wire logic pwm_3x_mode
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Assertions
   pump_off_a: assert property ((!sleep_request_low || over_temp) |=> !gate_pump_enable)
      else $error("pump on in sleep");
   low_dead_a: assert property ((low_gate_on & ~$past(low_gate_on)
      & ~$past(high_gate_off)) == 3'h0)
      else $error("low gate on early");
   high_dead_a: assert property ((high_gate_on & ~$past(high_gate_on)
      & ~$past(low_gate_off)) == 3'h0)
      else $error("high gate on early");
   no_cross_a: assert property ((high_gate_on & low_gate_on) == 3'h0)
      else $error("both gates on");
   slew_hold_a: assert property ($past(rstn, 3) && !serial_variant |-> $stable(slew_code))
      else $error("strap slew changed");
   gain_edge_a: assert property ($past(rstn, 2) && $changed(sense_amp_gain_setting)
      |-> ($past(low_side_pwm_input, 2) & ~$past(low_side_pwm_input)) != 3'h0)
      else $error("gain moved without low edge");
   ocp_demag_a: assert property (overcurrent_trip |=> !demag_active)
      else $error("demag during overcurrent");
   fault_od_a: assert property (fault_flag_low_o == 1'b0)
      else $error("fault pin driven high");
   mode_hold_a: assert property ($past(rstn, 3) |-> $stable(pwm_3x_mode))
      else $error("scheme changed");
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
// ==========================================================
// Both ends joined over the link
module tb;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] user_high_pwm = 3'h0, user_low_pwm = 3'h0;
   logic user_disable = 1'b0, user_sleep_low = 1'b1, user_serial_variant = 1'b0;
   logic [1:0] user_slew_strap = 2'h0, user_gain_strap = 2'h0, user_mode_strap = 2'h0;
   logic [1:0] user_cfg_slew = 2'h0, user_cfg_gain = 2'h0;
   logic user_cfg_write = 1'b0, user_sync_en = 1'b0, user_async_en = 1'b0;
   logic user_3x = 1'b0, user_rail_sel = 1'b0, user_fault;
   logic over_temp = 1'b0, overcurrent_trip = 1'b0, fault_event = 1'b0;
   logic [2:0] high_side_reverse_comparator = 3'h0, low_side_reverse_comparator = 3'h0;
   logic [2:0] high_gate_off = 3'h7, low_gate_off = 3'h7;
   logic [2:0] commutation_decay = 3'h0, current_near_zero = 3'h0;
   logic gate_pump_enable, demag_active, pwm_3x_mode, serial_out_rail;
   logic [1:0] slew_code, sense_amp_gain_setting;
   logic [2:0] high_gate_on, low_gate_on, phase_hiz, extra_delay_active;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   // Clock, 4 ns period
   always #2 ref_clk = ~ref_clk;
   bdcd_if lk ();
   bdcd_host i_bdcd_host (.ref_clk, .rstn, .user_high_pwm, .user_low_pwm, .user_disable,
      .user_sleep_low, .user_serial_variant, .user_slew_strap, .user_gain_strap,
      .user_mode_strap, .user_cfg_write, .user_cfg_slew, .user_cfg_gain, .user_sync_en,
      .user_async_en, .user_3x, .user_rail_sel, .user_fault, .link(lk));
   bdcd_device i_bdcd_device (.ref_clk, .rstn, .link(lk), .over_temp, .overcurrent_trip,
      .high_side_reverse_comparator, .low_side_reverse_comparator, .high_gate_off,
      .low_gate_off, .commutation_decay, .current_near_zero, .fault_event,
      .gate_pump_enable, .slew_code, .sense_amp_gain_setting, .high_gate_on, .low_gate_on,
      .phase_hiz, .demag_active, .pwm_3x_mode, .serial_out_rail, .extra_delay_active);
   bdcd_monitor i_bdcd_monitor (.ref_clk, .rstn, .sleep_request_low(lk.sleep_request_low),
      .serial_variant(lk.serial_variant), .low_side_pwm_input(lk.low_side_pwm_input),
      .fault_flag_low_o(lk.fault_flag_low_o), .over_temp, .overcurrent_trip,
      .high_gate_off, .low_gate_off, .gate_pump_enable, .slew_code,
      .sense_amp_gain_setting, .high_gate_on, .low_gate_on, .demag_active, .pwm_3x_mode);
   // ==========================================================
   // Shared tasks
   task automatic give_verdict();
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t %s: saw %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // Power-up with the given straps; scheme enables follow the mode code
   task automatic do_reset(input logic sv, input logic [1:0] slew, input logic [1:0] mode);
      rstn = 1'b0;
      user_serial_variant = sv;
      user_slew_strap = slew;
      user_mode_strap = mode;
      user_sync_en = mode[0];
      user_async_en = mode[0];
      user_3x = mode[1];
      step(3);
      rstn = 1'b1;
      step(3);
   endtask
   task automatic cfg_pulse();
      user_cfg_write = 1'b1;
      step(1);
      user_cfg_write = 1'b0;
      step(4);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_pump();
      user_sleep_low = 1'b0;
      step(3);
      check(3'(gate_pump_enable), 3'h0, "pump asleep");
      user_sleep_low = 1'b1;
      step(3);
      check(3'(gate_pump_enable), 3'h1, "pump awake");
      over_temp = 1'b1;
      step(2);
      check(3'(gate_pump_enable), 3'h0, "pump hot");
      check(3'(user_fault), 3'h1, "fault on overheat");
      over_temp = 1'b0;
      step(3);
      check(3'(user_fault), 3'h0, "fault released");
   endtask
   task automatic t_straps();
      for (int c = 0; c < 4; c++) begin
         do_reset(1'b0, 2'(c), 2'(c));
         user_slew_strap = 2'(~c);
         user_mode_strap = 2'(~c);
         step(4);
         check(3'(slew_code), 3'(c), "strap slew");
         check(3'(pwm_3x_mode), 3'(c / 2), "strap scheme");
      end
   endtask
   task automatic t_serial();
      do_reset(1'b1, 2'h0, 2'h0);
      for (int c = 3; c >= 0; c--) begin
         user_cfg_slew = 2'(c);
         cfg_pulse();
         check(3'(slew_code), 3'(c), "serial slew");
      end
      user_rail_sel = 1'b1;
      step(3);
      check(3'(serial_out_rail), 3'h1, "rail select");
   endtask
   task automatic t_gain();
      user_low_pwm = 3'h4;
      step(3);
      for (int g = 1; g < 4; g++) begin
         user_cfg_gain = 2'(g);
         cfg_pulse();
         check(3'(sense_amp_gain_setting), 3'(g - 1), "gain held");
         user_low_pwm = 3'h0;
         step(4);
         check(3'(sense_amp_gain_setting), 3'(g), "gain applied");
         user_low_pwm = 3'h4;
         step(3);
      end
      user_low_pwm = 3'h0;
   endtask
   task automatic t_dead();
      do_reset(1'b0, 2'h0, 2'h0);
      high_gate_off = 3'h0;
      user_low_pwm = 3'h1;
      step(4);
      check(low_gate_on, 3'h0, "low waits");
      high_gate_off = 3'h7;
      step(3);
      check(low_gate_on, 3'h1, "low on");
      check(phase_hiz, 3'h6, "phase 0 driven");
      user_low_pwm = 3'h0;
      low_gate_off = 3'h0;
      user_high_pwm = 3'h1;
      step(4);
      check(high_gate_on, 3'h0, "high waits");
      low_gate_off = 3'h7;
      step(3);
      check(high_gate_on, 3'h1, "high on");
      user_high_pwm = 3'h0;
      do_reset(1'b0, 2'h0, 2'h2);
      user_low_pwm = 3'h7;
      user_high_pwm = 3'h1;
      step(3);
      check(high_gate_on, 3'h1, "3x high");
      check(low_gate_on, 3'h6, "3x low");
      user_low_pwm = 3'h0;
      user_high_pwm = 3'h0;
   endtask
   task automatic t_ocp();
      do_reset(1'b1, 2'h0, 2'h1);
      check(3'(demag_active), 3'h1, "serial demag enable");
      do_reset(1'b0, 2'h0, 2'h1);
      low_side_reverse_comparator = 3'h7;
      step(3);
      check(3'(demag_active), 3'h1, "strap demag enable");
      check(low_gate_on, 3'h7, "low side rectifies");
      user_low_pwm = 3'h7;
      step(3);
      check(extra_delay_active, 3'h7, "delay window open");
      user_low_pwm = 3'h0;
      overcurrent_trip = 1'b1;
      step(2);
      check(3'(demag_active), 3'h0, "demag in overcurrent");
      check(low_gate_on, 3'h0, "rectification stopped");
      check(3'(user_fault), 3'h1, "fault on overcurrent");
      overcurrent_trip = 1'b0;
      low_side_reverse_comparator = 3'h0;
      step(80);
      check(extra_delay_active, 3'h0, "delay window closed");
   endtask
   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      do_reset(1'b0, 2'h0, 2'h0);
      t_pump();
      t_straps();
      t_serial();
      t_gain();
      t_dead();
      t_ocp();
      give_verdict();
   end
endmodule
